/* hw/dgsc_top.sv */
// gain selection, soft start and start braking sequencer
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dgsc_defines.svh"
module dgsc_top import dgsc_pkg::*; #(
  parameter int MS_CYCLES = `DGSC_MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic run_cmd,
  input wire logic gain_toggle_input,
  input wire logic prop_only_select_input,
  input wire logic [15:0] output_freq,
  input wire logic [15:0] freq_command,
  output dgsc_gain_t gain_out,
  output dgsc_start_t start_out
);

  logic [1:0] rst_sync;
  logic rst_n;
  logic [2:0] run_s, tog_s, po_s;
  logic run_q, tog_q, po_q, run_prev;
  logic [1:0] gain_switch_mode_sel;
  logic [13:0] gain_transition_time;
  logic [15:0] map_mid_freq_1, map_mid_freq_2, map_top_freq;
  logic [15:0] gain_reg [`DGSC_GAIN_REGS];
  logic [7:0] control_method_sel;
  logic [9:0] start_min_freq;
  logic [10:0] soft_start_ramp_time;
  logic [1:0] dc_brake_mode_sel;
  logic [15:0] dc_brake_threshold_freq;
  logic [6:0] start_brake_force;
  logic [12:0] start_brake_duration;
  logic [7:0] carrier_freq_setting;
  logic light_load_rating;
  logic [31:0] ms_cnt;
  logic ms_tick, cs_tick;
  logic [3:0] cs_cnt;
  logic [12:0] brake_cnt;
  dgsc_state_t state, next_state;
  logic [1:0] next_stage;
  logic [15:0] next_p, next_i;
  logic next_integ;
  logic [15:0] from_p, from_i, to_p, to_i;
  logic to_integ;
  logic [1:0] cur_stage;
  logic cur_po;
  logic gain_restart;
  logic [10:0] gain_frac, volt_frac;
  logic gain_done, soft_done;
  logic soft_restart;
  logic is_vf;
  logic setfreq_brake;
  logic [10:0] force_lvl;
  logic [9:0] brake_lvl;
  logic [15:0] blend_p, blend_i;

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // three-stage synchronisers on the terminal inputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_s <= 3'h0;
      tog_s <= 3'h0;
      po_s <= 3'h0;
    end else begin
      run_s <= {run_s[1:0], run_cmd};
      tog_s <= {tog_s[1:0], gain_toggle_input};
      po_s <= {po_s[1:0], prop_only_select_input};
    end
  end

  // a level counts once the last two stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      tog_q <= 1'b0;
      po_q <= 1'b0;
    end else begin
      if (run_s[1] == run_s[2]) run_q <= run_s[2];
      if (tog_s[1] == tog_s[2]) tog_q <= tog_s[2];
      if (po_s[1] == po_s[2]) po_q <= po_s[2];
    end
  end

  // millisecond and ten-millisecond enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt <= '0;
      cs_cnt <= 4'h0;
    end else begin
      if (ms_cnt == 32'(MS_CYCLES - 1)) begin
        ms_cnt <= '0;
        cs_cnt <= (cs_cnt == 4'(`DGSC_CS_PER_MS - 1)) ? 4'h0 : cs_cnt + 4'h1;
      end else begin
        ms_cnt <= ms_cnt + 32'h1;
      end
    end
  end
  assign ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));
  assign cs_tick = ms_tick && (cs_cnt == 4'(`DGSC_CS_PER_MS - 1));

  // register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_switch_mode_sel <= `DGSC_MODE_TERMINAL;
      gain_transition_time <= `DGSC_RST_GAIN_TIME;
      map_mid_freq_1 <= 16'h0000;
      map_mid_freq_2 <= 16'h0000;
      map_top_freq <= 16'h0000;
      for (int k = 0; k < `DGSC_GAIN_REGS; k++) gain_reg[k] <= `DGSC_RST_GAIN;
      control_method_sel <= `DGSC_CTRL_VF;
      start_min_freq <= `DGSC_RST_MIN_FREQ;
      soft_start_ramp_time <= `DGSC_RST_SOFT_TIME;
      dc_brake_mode_sel <= `DGSC_BRAKE_OFF;
      dc_brake_threshold_freq <= `DGSC_RST_BRAKE_THR;
      start_brake_force <= 7'h00;
      start_brake_duration <= 13'h0000;
      carrier_freq_setting <= `DGSC_RST_CARRIER;
      light_load_rating <= 1'b0;
    end else if (wr) begin
      unique case (addr)
        `DGSC_REG_GAIN_MODE: gain_switch_mode_sel <= wdata[1:0];
        `DGSC_REG_GAIN_TIME: gain_transition_time <= wdata[13:0];
        `DGSC_REG_MAP_MID1: map_mid_freq_1 <= wdata[15:0];
        `DGSC_REG_MAP_MID2: map_mid_freq_2 <= wdata[15:0];
        `DGSC_REG_MAP_TOP: map_top_freq <= wdata[15:0];
        `DGSC_REG_CTRL_METHOD: control_method_sel <= wdata[7:0];
        `DGSC_REG_MIN_FREQ: start_min_freq <= wdata[9:0];
        `DGSC_REG_SOFT_TIME: soft_start_ramp_time <= wdata[10:0];
        `DGSC_REG_BRAKE_MODE: dc_brake_mode_sel <= wdata[1:0];
        `DGSC_REG_BRAKE_THR: dc_brake_threshold_freq <= wdata[15:0];
        `DGSC_REG_BRAKE_FORCE: start_brake_force <= wdata[6:0];
        `DGSC_REG_BRAKE_TIME: start_brake_duration <= wdata[12:0];
        `DGSC_REG_CARRIER: carrier_freq_setting <= wdata[7:0];
        `DGSC_REG_RATING: light_load_rating <= wdata[0];
        default: begin
          for (int k = 0; k < `DGSC_GAIN_REGS; k++) begin
            if (addr == 8'(`DGSC_REG_GAIN_BASE + 4 * k)) gain_reg[k] <= wdata[15:0];
          end
        end
      endcase
    end
  end

  // register reads, data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0;
    end else if (rd) begin
      rdata <= 32'h0;
      unique case (addr)
        `DGSC_REG_GAIN_MODE: rdata <= {30'h0, gain_switch_mode_sel};
        `DGSC_REG_GAIN_TIME: rdata <= {18'h0, gain_transition_time};
        `DGSC_REG_MAP_MID1: rdata <= {16'h0, map_mid_freq_1};
        `DGSC_REG_MAP_MID2: rdata <= {16'h0, map_mid_freq_2};
        `DGSC_REG_MAP_TOP: rdata <= {16'h0, map_top_freq};
        `DGSC_REG_CTRL_METHOD: rdata <= {24'h0, control_method_sel};
        `DGSC_REG_MIN_FREQ: rdata <= {22'h0, start_min_freq};
        `DGSC_REG_SOFT_TIME: rdata <= {21'h0, soft_start_ramp_time};
        `DGSC_REG_BRAKE_MODE: rdata <= {30'h0, dc_brake_mode_sel};
        `DGSC_REG_BRAKE_THR: rdata <= {16'h0, dc_brake_threshold_freq};
        `DGSC_REG_BRAKE_FORCE: rdata <= {25'h0, start_brake_force};
        `DGSC_REG_BRAKE_TIME: rdata <= {19'h0, start_brake_duration};
        `DGSC_REG_CARRIER: rdata <= {24'h0, carrier_freq_setting};
        `DGSC_REG_RATING: rdata <= {31'h0, light_load_rating};
        `DGSC_REG_STATUS: rdata <= {24'h0, gain_out.blending, start_out.brake_on, to_integ,
                                    cur_stage, state, start_out.freq_en};
        `DGSC_REG_OUT_FREQ: rdata <= {16'h0, output_freq};
        default: begin
          for (int k = 0; k < `DGSC_GAIN_REGS; k++) begin
            if (addr == 8'(`DGSC_REG_GAIN_BASE + 4 * k)) rdata <= {16'h0, gain_reg[k]};
          end
        end
      endcase
    end
  end

  // stage choice from the terminal or from the output frequency map
  always_comb begin
    next_stage = 2'd0;
    if (gain_switch_mode_sel == `DGSC_MODE_MAPPING) begin
      if (map_top_freq != 16'h0 && output_freq >= map_top_freq) next_stage = 2'd3;
      else if (map_mid_freq_2 != 16'h0 && output_freq >= map_mid_freq_2) next_stage = 2'd2;
      else if (map_mid_freq_1 != 16'h0 && output_freq >= map_mid_freq_1) next_stage = 2'd1;
      else next_stage = 2'd0;
    end else begin
      next_stage = tog_q ? 2'd1 : 2'd0;
    end
  end

  // gain values for the chosen stage and P-only select
  always_comb begin
    next_p = gain_reg[`DGSC_G_P1];
    next_i = gain_reg[`DGSC_G_I1];
    next_integ = 1'b1;
    if (po_q) begin
      next_integ = 1'b0;
      next_i = 16'h0000;
      next_p = (next_stage == 2'd0) ? gain_reg[`DGSC_G_PO1] : gain_reg[`DGSC_G_PO2];
    end else begin
      unique case (next_stage)
        2'd0: begin
          next_p = gain_reg[`DGSC_G_P1];
          next_i = gain_reg[`DGSC_G_I1];
        end
        2'd1: begin
          next_p = gain_reg[`DGSC_G_P2];
          next_i = gain_reg[`DGSC_G_I2];
        end
        2'd2: begin
          next_p = gain_reg[`DGSC_G_P3];
          next_i = gain_reg[`DGSC_G_I3];
        end
        2'd3: begin
          next_p = gain_reg[`DGSC_G_P4];
          next_i = gain_reg[`DGSC_G_I4];
        end
      endcase
    end
  end

  // on a change of selection, blend from the applied gain to the new one
  assign gain_restart = (next_stage != cur_stage) || (po_q != cur_po);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_stage <= 2'd0;
      cur_po <= 1'b0;
      from_p <= `DGSC_RST_GAIN;
      from_i <= `DGSC_RST_GAIN;
      to_p <= `DGSC_RST_GAIN;
      to_i <= `DGSC_RST_GAIN;
      to_integ <= 1'b1;
    end else begin
      cur_stage <= next_stage;
      cur_po <= po_q;
      to_p <= next_p;
      to_i <= next_i;
      to_integ <= next_integ;
      if (gain_restart) begin
        from_p <= blend_p;
        from_i <= blend_i;
      end
    end
  end

  dgsc_ramp #(.DUR_W(14)) u_gain_ramp (
    .clk(clk),
    .rst_n(rst_n),
    .tick(ms_tick),
    .restart(gain_restart),
    .dur(gain_transition_time),
    .frac(gain_frac),
    .done(gain_done)
  );

  // linear blend of proportional and integral gains
  always_comb begin
    logic signed [17:0] dp, di;
    logic signed [29:0] mp, mi;
    dp = 18'($signed({2'b00, to_p}) - $signed({2'b00, from_p}));
    di = 18'($signed({2'b00, to_i}) - $signed({2'b00, from_i}));
    mp = 30'(dp) * 30'($signed({1'b0, gain_frac}));
    mi = 30'(di) * 30'($signed({1'b0, gain_frac}));
    blend_p = 16'($signed({2'b00, from_p}) + 18'(mp >>> `DGSC_FRAC_SHIFT));
    blend_i = 16'($signed({2'b00, from_i}) + 18'(mi >>> `DGSC_FRAC_SHIFT));
  end

  // gain output register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_out <= '{p_gain: `DGSC_RST_GAIN, i_gain: `DGSC_RST_GAIN, integ_en: 1'b1,
                    stage: 2'd0, blending: 1'b0};
    end else begin
      gain_out <= '{p_gain: blend_p, i_gain: to_integ ? blend_i : 16'h0000, integ_en: to_integ,
                    stage: cur_stage, blending: !gain_done};
    end
  end

  // start sequencing
  assign is_vf = (control_method_sel == `DGSC_CTRL_VF);
  always_comb begin
    next_state = state;
    unique case (state)
      DGSC_IDLE: begin
        if (run_q && !run_prev) begin
          if (dc_brake_mode_sel == `DGSC_BRAKE_START && start_brake_duration != 13'h0) begin
            next_state = DGSC_BRAKE;
          end else if (is_vf) begin
            next_state = DGSC_SOFT;
          end else begin
            next_state = DGSC_RUN;
          end
        end
      end
      DGSC_BRAKE: begin
        if (!run_q) next_state = DGSC_IDLE;
        else if (cs_tick && brake_cnt == start_brake_duration - 13'h1) begin
          next_state = is_vf ? DGSC_SOFT : DGSC_RUN;
        end
      end
      DGSC_SOFT: begin
        if (!run_q) next_state = DGSC_IDLE;
        else if (soft_done) next_state = DGSC_RUN;
      end
      DGSC_RUN: begin
        if (!run_q) next_state = DGSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DGSC_IDLE;
      run_prev <= 1'b0;
    end else begin
      state <= next_state;
      run_prev <= run_q;
    end
  end

  // start braking time in hundredths of a second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brake_cnt <= 13'h0;
    end else if (state != DGSC_BRAKE) begin
      brake_cnt <= 13'h0;
    end else if (cs_tick) begin
      brake_cnt <= brake_cnt + 13'h1;
    end
  end

  assign soft_restart = (state != DGSC_SOFT) && (next_state == DGSC_SOFT);
  dgsc_ramp #(.DUR_W(11)) u_soft_ramp (
    .clk(clk),
    .rst_n(rst_n),
    .tick(ms_tick),
    .restart(soft_restart),
    .dur(soft_start_ramp_time),
    .frac(volt_frac),
    .done(soft_done)
  );

  // braking level: rating scale, then carrier limit
  assign setfreq_brake = (dc_brake_mode_sel == `DGSC_BRAKE_SETFREQ) && run_q
                         && (freq_command < dc_brake_threshold_freq)
                         && (output_freq < dc_brake_threshold_freq);
  // both factors widened first so the product keeps all eleven bits
  assign force_lvl = {4'h0, start_brake_force}
                     * {7'h00, (light_load_rating ? `DGSC_LIGHT_LOAD_SCALE : `DGSC_STD_LOAD_SCALE)};
  assign brake_lvl = (carrier_freq_setting > `DGSC_CARRIER_2KHZ && force_lvl > 11'(`DGSC_BRAKE_LIMIT))
                     ? `DGSC_BRAKE_LIMIT : force_lvl[9:0];

  // start output register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_out <= '0;
    end else begin
      start_out.freq_en <= ((state == DGSC_SOFT) || (state == DGSC_RUN)) && !setfreq_brake;
      start_out.freq_floor <= start_min_freq;
      start_out.volt_frac <= (state == DGSC_SOFT) ? volt_frac
                             : (state == DGSC_RUN) ? `DGSC_FRAC_ONE : 11'h000;
      start_out.brake_on <= (state == DGSC_BRAKE) || setfreq_brake;
      start_out.brake_level <= ((state == DGSC_BRAKE) || setfreq_brake) ? brake_lvl : 10'h000;
    end
  end

endmodule : dgsc_top
`default_nettype wire

/* hw/dgsc_defines.svh */
// constants of the drive gain select and start control block
`ifndef DGSC_DEFINES_SVH
`define DGSC_DEFINES_SVH

// clock and time base
`define DGSC_CLK_HZ 250000000
`define DGSC_TICK_MS 1
`define DGSC_MS_CYCLES (`DGSC_CLK_HZ / 1000 * `DGSC_TICK_MS)
`define DGSC_CS_PER_MS 10
`define DGSC_FRAC_ONE 11'h400
`define DGSC_FRAC_SHIFT 10

// register byte offsets
`define DGSC_REG_GAIN_MODE 8'h00
`define DGSC_REG_GAIN_TIME 8'h04
`define DGSC_REG_MAP_MID1 8'h08
`define DGSC_REG_MAP_MID2 8'h0c
`define DGSC_REG_MAP_TOP 8'h10
`define DGSC_REG_GAIN_BASE 8'h14
`define DGSC_REG_CTRL_METHOD 8'h3c
`define DGSC_REG_MIN_FREQ 8'h40
`define DGSC_REG_SOFT_TIME 8'h44
`define DGSC_REG_BRAKE_MODE 8'h48
`define DGSC_REG_BRAKE_THR 8'h4c
`define DGSC_REG_BRAKE_FORCE 8'h50
`define DGSC_REG_BRAKE_TIME 8'h54
`define DGSC_REG_CARRIER 8'h58
`define DGSC_REG_RATING 8'h5c
`define DGSC_REG_STATUS 8'h60
`define DGSC_REG_OUT_FREQ 8'h64
`define DGSC_GAIN_REGS 10

// gain table slots
`define DGSC_G_P1 0
`define DGSC_G_I1 1
`define DGSC_G_PO1 2
`define DGSC_G_P2 3
`define DGSC_G_I2 4
`define DGSC_G_PO2 5
`define DGSC_G_P3 6
`define DGSC_G_I3 7
`define DGSC_G_P4 8
`define DGSC_G_I4 9

// codes
`define DGSC_MODE_TERMINAL 2'h0
`define DGSC_MODE_MAPPING 2'h1
`define DGSC_BRAKE_OFF 2'h0
`define DGSC_BRAKE_START 2'h1
`define DGSC_BRAKE_SETFREQ 2'h2
`define DGSC_CTRL_VF 8'h00
`define DGSC_CTRL_SLV_IM 8'h08

// reset values
`define DGSC_RST_GAIN_TIME 14'h0064
`define DGSC_RST_GAIN 16'h03e8
`define DGSC_RST_MIN_FREQ 10'h032
`define DGSC_RST_SOFT_TIME 11'h00c
`define DGSC_RST_BRAKE_THR 16'h0032
`define DGSC_RST_CARRIER 8'h14

// braking force scaling, units of 0.1% of rated current
`define DGSC_STD_LOAD_SCALE 4'ha
`define DGSC_LIGHT_LOAD_SCALE 4'h7
`define DGSC_CARRIER_2KHZ 8'h14
`define DGSC_BRAKE_LIMIT 10'h1f4

`endif

/* hw/dgsc_pkg.sv */
// types of the drive gain select and start control block
package dgsc_pkg;

  typedef enum logic [1:0] {
    DGSC_IDLE,
    DGSC_BRAKE,
    DGSC_SOFT,
    DGSC_RUN
  } dgsc_state_t;

  // gain set presented to the speed regulator
  typedef struct packed {
    logic [15:0] p_gain;
    logic [15:0] i_gain;
    logic integ_en;
    logic [1:0] stage;
    logic blending;
  } dgsc_gain_t;

  // start and braking commands to the power stage
  typedef struct packed {
    logic freq_en;
    logic [9:0] freq_floor;
    logic [10:0] volt_frac;
    logic brake_on;
    logic [9:0] brake_level;
  } dgsc_start_t;

endpackage : dgsc_pkg

/* hw/dgsc_ramp.sv */
// linear 0 to one ramp over a duration counted in ticks
`timescale 1ns/1ps
`default_nettype none
`include "dgsc_defines.svh"
module dgsc_ramp import dgsc_pkg::*; #(
  parameter int DUR_W = 14
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic restart,
  input wire logic [DUR_W-1:0] dur,
  output logic [10:0] frac,
  output logic done
);

  logic [DUR_W+1:0] acc;

  // each tick adds one unit, spare cycles divide it down into fraction steps
  // a tick period needs about 1024/dur spare cycles, or the ramp runs slow
  // out of reset the ramp rests at full scale, so nothing reads as blending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      frac <= `DGSC_FRAC_ONE;
    end else if (restart) begin
      acc <= '0;
      frac <= (dur == '0) ? `DGSC_FRAC_ONE : 11'h000;
    end else if (frac < `DGSC_FRAC_ONE) begin
      if (tick) begin
        acc <= acc + (DUR_W+2)'(`DGSC_FRAC_ONE);
      end else if (acc >= {2'b00, dur}) begin
        acc <= acc - {2'b00, dur};
        frac <= frac + 11'h001;
      end
    end
  end

  assign done = (frac == `DGSC_FRAC_ONE);

endmodule : dgsc_ramp
`default_nettype wire

/* tb/dgsc_properties.sv */
// concurrent checks on the ports of the gain select and start sequencer
`timescale 1ns/1ps
`default_nettype none
module dgsc_properties import dgsc_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run_cmd,
  input wire dgsc_gain_t gain_out,
  input wire dgsc_start_t start_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // run dropped and stayed low long enough to cross the input synchroniser
  sequence s_run_drop;
    $fell(run_cmd) ##1 !run_cmd [*4];
  endsequence
  // braking ends while the run command is still held
  sequence s_brake_end;
    $fell(start_out.brake_on) ##0 run_cmd;
  endsequence

  // proportional-only operation carries no integral gain
  a_integ_off_zero: assert property (!gain_out.integ_en |-> gain_out.i_gain == 16'h0000)
    else $error("integral gain not zero in proportional-only operation");
  // no frequency output while the dc brake is applied
  a_brake_no_freq: assert property (start_out.brake_on |-> !start_out.freq_en)
    else $error("frequency output during braking");
  // stopping clears output, voltage and brake within a few cycles
  a_stop_clears: assert property (s_run_drop |-> ##[0:4] (!start_out.freq_en &&
    !start_out.brake_on && start_out.volt_frac == 11'h000))
    else $error("outputs not cleared after run dropped");
  // frequency output follows the end of start braking
  a_brake_then_freq: assert property (s_brake_end |-> ##[0:2] start_out.freq_en)
    else $error("no frequency output after start braking");
  // voltage fraction never exceeds full scale
  a_volt_cap: assert property (start_out.volt_frac <= 11'h400)
    else $error("voltage fraction above full scale");
  // voltage never falls while output continues
  a_volt_rises: assert property (start_out.freq_en && $past(start_out.freq_en) |->
    start_out.volt_frac >= $past(start_out.volt_frac))
    else $error("voltage fell during output");
  // output always starts from a nonzero minimum frequency
  a_floor_set: assert property (start_out.freq_en |-> start_out.freq_floor != 10'h000)
    else $error("zero minimum frequency during output");
  // braking level stays within rated current
  a_brake_cap: assert property (start_out.brake_on |-> start_out.brake_level <= 10'h3e8)
    else $error("braking level above rated current");
endmodule : dgsc_properties
`default_nettype wire

/* tb/dgsc_stage_model.sv */
// power stage and motor model: speed follows the start commands
`timescale 1ns/1ps
`default_nettype none
module dgsc_stage_model import dgsc_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire dgsc_start_t start_out,
  input wire logic [15:0] spd,
  output logic [15:0] output_freq
);
  // shaft stands during braking or idle, else at least the minimum frequency
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      output_freq <= 16'h0000;
    end else if (start_out.brake_on || !start_out.freq_en) begin
      output_freq <= 16'h0000;
    end else if (spd < {6'h00, start_out.freq_floor}) begin
      output_freq <= {6'h00, start_out.freq_floor};
    end else begin
      output_freq <= spd;
    end
  end
endmodule : dgsc_stage_model
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the gain select and start sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dgsc_defines.svh"
module testbench import dgsc_pkg::*; ();
  typedef struct packed {
    logic [1:0] m;
    logic po;
    logic tg;
    logic [15:0] f;
    logic [3:0] pk;
    logic [3:0] ik;
    logic ie;
    logic [1:0] st;
  } dgsc_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic run_cmd = 1'b0;
  logic gain_toggle_input = 1'b0;
  logic prop_only_select_input = 1'b0;
  logic [15:0] freq_command = 16'h1000;
  logic [15:0] spd = 16'h0000;
  logic [15:0] output_freq;
  logic [31:0] rdata;
  dgsc_gain_t gain_out;
  dgsc_start_t start_out;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  dgsc_row_t rows [11] = '{
    '{2'h0, 1'b0, 1'b0, 16'h0000, 4'h0, 4'h1, 1'b1, 2'h0},
    '{2'h0, 1'b0, 1'b1, 16'h0000, 4'h3, 4'h4, 1'b1, 2'h1},
    '{2'h0, 1'b1, 1'b0, 16'h0000, 4'h2, 4'h0, 1'b0, 2'h0},
    '{2'h0, 1'b1, 1'b1, 16'h0000, 4'h5, 4'h0, 1'b0, 2'h1},
    '{2'h1, 1'b0, 1'b0, 16'h0000, 4'h0, 4'h1, 1'b1, 2'h0},
    '{2'h1, 1'b0, 1'b0, 16'h03e7, 4'h0, 4'h1, 1'b1, 2'h0},
    '{2'h1, 1'b0, 1'b0, 16'h05dc, 4'h3, 4'h4, 1'b1, 2'h1},
    '{2'h1, 1'b0, 1'b0, 16'h07d0, 4'h6, 4'h7, 1'b1, 2'h2},
    '{2'h1, 1'b0, 1'b0, 16'h0bb8, 4'h8, 4'h9, 1'b1, 2'h3},
    '{2'h1, 1'b1, 1'b0, 16'h0000, 4'h2, 4'h0, 1'b0, 2'h0},
    '{2'h1, 1'b1, 1'b0, 16'h09c4, 4'h5, 4'h0, 1'b0, 2'h2}};

  dgsc_top #(.MS_CYCLES(10)) dut_u (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .run_cmd(run_cmd), .gain_toggle_input(gain_toggle_input),
    .prop_only_select_input(prop_only_select_input), .output_freq(output_freq),
    .freq_command(freq_command), .gain_out(gain_out), .start_out(start_out));
  dgsc_stage_model stage_u (.clk(clk), .rst_b(rst_b), .start_out(start_out), .spd(spd),
    .output_freq(output_freq));

  // 250 MHz clock and a cycle ceiling against hangs
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic final_report;
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask : wt

  // register write and read-compare, entered right after a rising edge
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    wt(1);
    wr <= 1'b0;
    wt(1);
  endtask : bw

  task automatic br(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    wt(1);
    rd <= 1'b0;
    wt(1);
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask : br

  task automatic run(input logic v);
    run_cmd <= v;
    wt(v ? 1 : 8);
  endtask : run

  // start braking with a given force, rating and carrier
  task automatic sb(input logic [6:0] f, input logic lite, input logic [7:0] cr, input logic [9:0] e);
    bw(`DGSC_REG_BRAKE_FORCE, {25'h0, f});
    bw(`DGSC_REG_RATING, {31'h0, lite});
    bw(`DGSC_REG_CARRIER, {24'h0, cr});
    run(1'b1);
    for (n = 0; n < 20 && start_out.brake_on !== 1'b1; n++) wt(1);
    chk("brake_level", e, start_out.brake_level);
    for (n = 0; n < 400 && start_out.brake_on === 1'b1; n++) wt(1);
    wt(2);
    chk("brake_len", 1, n >= 100 && n <= 210);
    chk("freq_after", 1, start_out.freq_en);
    run(1'b0);
  endtask : sb

  initial begin
    wt(6);
    rst_b <= 1'b1;
    wt(3);
    bw(`DGSC_REG_CTRL_METHOD, 32'h08);
    bw(`DGSC_REG_GAIN_TIME, 32'h0);
    for (int k = 0; k < 10; k++) bw(`DGSC_REG_GAIN_BASE + 8'(4 * k), 32'h100 + k);
    bw(`DGSC_REG_MAP_MID1, 32'h3e8);
    bw(`DGSC_REG_MAP_MID2, 32'h7d0);
    bw(`DGSC_REG_MAP_TOP, 32'hbb8);
    run(1'b1);
    // gain selection table
    foreach (rows[r]) begin
      bw(`DGSC_REG_GAIN_MODE, {30'h0, rows[r].m});
      prop_only_select_input <= rows[r].po;
      gain_toggle_input <= rows[r].tg;
      spd <= rows[r].f;
      wt(12);
      chk("p_gain", 16'h0100 + rows[r].pk, gain_out.p_gain);
      chk("i_gain", rows[r].ie ? 16'h0100 + rows[r].ik : 16'h0, gain_out.i_gain);
      chk("integ_en", rows[r].ie, gain_out.integ_en);
      chk("stage", rows[r].st, gain_out.stage);
    end
    prop_only_select_input <= 1'b0;
    run(1'b0);
    // gain blend over 120 ms, long enough for the short test tick
    bw(`DGSC_REG_GAIN_TIME, 32'h78);
    bw(`DGSC_REG_GAIN_MODE, 32'h0);
    gain_toggle_input <= 1'b1;
    wt(7);
    chk("blending", 1, gain_out.blending);
    wt(1300);
    chk("blend_end", {1'b0, 16'h0103}, {gain_out.blending, gain_out.p_gain});
    gain_toggle_input <= 1'b0;
    // soft start under V/f, then none under vector control
    bw(`DGSC_REG_CTRL_METHOD, 32'h00);
    bw(`DGSC_REG_SOFT_TIME, 32'h78);
    bw(`DGSC_REG_MIN_FREQ, 32'h64);
    run(1'b1);
    for (n = 0; n < 20 && start_out.freq_en !== 1'b1; n++) wt(1);
    chk("freq_floor", 10'h064, start_out.freq_floor);
    wt(600);
    chk("volt_mid", 1, start_out.volt_frac > 0 && start_out.volt_frac < 11'h400);
    wt(700);
    chk("volt_full", 11'h400, start_out.volt_frac);
    run(1'b0);
    bw(`DGSC_REG_CTRL_METHOD, 32'h08);
    run(1'b1);
    for (n = 0; n < 20 && start_out.freq_en !== 1'b1; n++) wt(1);
    chk("volt_direct", 11'h400, start_out.volt_frac);
    run(1'b0);
    // start braking: plain, light load rating, carrier above 2 kHz
    bw(`DGSC_REG_BRAKE_MODE, 32'h1);
    bw(`DGSC_REG_BRAKE_TIME, 32'h2);
    sb(7'h32, 1'b0, 8'h14, 10'h1f4);
    sb(7'h64, 1'b1, 8'h14, 10'h2bc);
    sb(7'h64, 1'b0, 8'h1e, 10'h1f4);
    // braking by set frequency, then braking disabled
    bw(`DGSC_REG_BRAKE_MODE, 32'h2);
    freq_command <= 16'h0020;
    spd <= 16'h0100;
    run(1'b1);
    wt(10);
    chk("setf_brake", 2'b10, {start_out.brake_on, start_out.freq_en});
    freq_command <= 16'h1000;
    wt(10);
    chk("setf_release", 2'b01, {start_out.brake_on, start_out.freq_en});
    run(1'b0);
    bw(`DGSC_REG_BRAKE_MODE, 32'h0);
    freq_command <= 16'h0020;
    run(1'b1);
    wt(10);
    chk("brake_off", 2'b01, {start_out.brake_on, start_out.freq_en});
    run(1'b0);
    // second reset: outputs and register defaults
    rst_b <= 1'b0;
    wt(2);
    chk("start_rst", 40'h0, start_out);
    chk("p_rst", 16'h03e8, gain_out.p_gain);
    rst_b <= 1'b1;
    wt(3);
    br(`DGSC_REG_MIN_FREQ, 32'h32);
    br(`DGSC_REG_SOFT_TIME, 32'hc);
    br(`DGSC_REG_GAIN_TIME, 32'h64);
    br(`DGSC_REG_BRAKE_MODE, 32'h0);
    br(`DGSC_REG_BRAKE_FORCE, 32'h0);
    br(`DGSC_REG_BRAKE_TIME, 32'h0);
    bw(`DGSC_REG_STATUS, 32'hff);
    br(`DGSC_REG_STATUS, 32'h20);
    br(8'h70, 32'h0);
    final_report();
  end
endmodule : testbench

bind dgsc_top dgsc_properties chk_u (.clk(clk), .rst_b(rst_b), .run_cmd(run_cmd), .gain_out(gain_out),
  .start_out(start_out));
`default_nettype wire
